// ### design/btc_capture.v
`timescale 1ns/100ps
`default_nettype none
`include "btc_defines.vh"

module btc_capture (
   // Clock and reset
   input wire core_clk,
   input wire sys_rst,
   // Register port
   input wire [7:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr_stb,
   input wire reg_rd_stb,
   output reg [15:0] reg_rdata,
   // Observed backplane cycle (pins)
   input wire bus_strobe,
   input wire [7:0] bus_bank,
   input wire [15:0] bus_phys_addr,
   input wire [3:0] page_table_number,
   input wire [15:0] bus_log_addr,
   input wire [15:0] bus_data,
   input wire io_transfer_cycle,
   input wire bus_write,
   input wire bus_dma,
   input wire bus_instr,
   input wire alternate_table_flag,
   input wire interrupts_on_flag,
   input wire paging_on_flag,
   input wire [3:0] bus_level,
   // Processor stop
   input wire cpu_stopped,
   output reg cpu_stop_req,
   // DMA master for memory dump
   output reg dma_req,
   output reg [7:0] dma_bank,
   output reg [15:0] dma_addr,
   input wire dma_ack,
   input wire [15:0] dma_rdata
);

   localparam SW = 90;

   // Capture states, binary coded; same codes as the status field
   localparam [2:0] ST_IDLE = `BTC_ST_IDLE;
   localparam [2:0] ST_CLEAR = `BTC_ST_CLEAR;
   localparam [2:0] ST_ARMED = `BTC_ST_ARMED;
   localparam [2:0] ST_POST = `BTC_ST_POST;
   localparam [2:0] ST_FILLED = `BTC_ST_FILLED;
   localparam [2:0] ST_ABORTED = `BTC_ST_ABORTED;

   // Pin synchronisers; first stage feeds only the second
   // Fields share the strobe's two stages, so they stay aligned to it
   reg [SW-1:0] pin_meta_reg;
   reg [SW-1:0] pin_sync_reg;
   always @(posedge core_clk) begin
      pin_meta_reg <= {bus_strobe, bus_bank, bus_phys_addr, page_table_number,
         bus_log_addr, bus_data, io_transfer_cycle, bus_write, bus_dma,
         bus_instr, alternate_table_flag, interrupts_on_flag, paging_on_flag,
         bus_level, cpu_stopped, dma_ack, dma_rdata};
      pin_sync_reg <= pin_meta_reg;
   end

   wire s_strobe = pin_sync_reg[89];
   wire [7:0] s_bank = pin_sync_reg[88:81];
   wire [15:0] s_phys = pin_sync_reg[80:65];
   wire [3:0] s_ptn = pin_sync_reg[64:61];
   wire [15:0] s_log = pin_sync_reg[60:45];
   wire [15:0] s_data = pin_sync_reg[44:29];
   wire s_iox = pin_sync_reg[28];
   wire s_wr = pin_sync_reg[27];
   wire s_dma = pin_sync_reg[26];
   wire s_inst = pin_sync_reg[25];
   wire s_apt = pin_sync_reg[24];
   wire s_ion = pin_sync_reg[23];
   wire s_pon = pin_sync_reg[22];
   wire [3:0] s_level = pin_sync_reg[21:18];
   wire s_stopped = pin_sync_reg[17];
   wire s_ack = pin_sync_reg[16];
   wire [15:0] s_rdata = pin_sync_reg[15:0];

   // Edge detection on synchronised levels
   reg strobe_d_reg;
   reg stopped_d_reg;
   always @(posedge core_clk) begin
      if (sys_rst) begin
         strobe_d_reg <= 1'b0;
         stopped_d_reg <= 1'b0;
      end else begin
         strobe_d_reg <= s_strobe;
         stopped_d_reg <= s_stopped;
      end
   end
   // Only cycles seen on this backplane arrive here
   wire cyc_ev = s_strobe & ~strobe_d_reg;
   wire stop_ev = s_stopped & ~stopped_d_reg;

   // Flag field; instruction bit set on every fetch
   wire [6:0] cyc_flags = {s_iox, s_wr, ~s_dma, s_inst, s_apt, s_ion,
      s_pon};

   // Match vector shared by select words
   wire [47:0] cyc_vec = {s_bank, 1'b0, cyc_flags, s_phys, s_data};

   // Select word storage: 3 words of 8 slots
   reg [15:0] cfg_reg [0:23];
   wire [2:0] sw_hit;

   // One comparator per select word, care bit 1 means compare
   genvar w;
   generate
      for (w = 0; w < 3; w = w + 1) begin : g_sel
         wire [47:0] val = {cfg_reg[w*8+2], cfg_reg[w*8+1], cfg_reg[w*8]};
         wire [47:0] care = {cfg_reg[w*8+`BTC_SW_CARE+2],
            cfg_reg[w*8+`BTC_SW_CARE+1], cfg_reg[w*8+`BTC_SW_CARE]};
         wire [15:0] lvl = cfg_reg[w*8+`BTC_SW_LEVEL];
         // All fields must agree at once
         assign sw_hit[w] = (((cyc_vec ^ val) & care) == 48'h0) &
            lvl[s_level];
      end
   endgenerate

   // Console and clock IO cycles are dropped entirely
   wire io_excl = s_iox & ((s_log[9:0] == `BTC_DEV_CONSOLE) |
      (s_log[9:0] == `BTC_DEV_RTC));

   // Control and capture state
   reg [2:0] state_reg;
   reg stop_en_reg;
   reg stop_trig_reg;
   reg [11:0] trig_pos_reg;
   reg [11:0] wr_ptr_reg;
   reg [11:0] trig_idx_reg;
   reg [11:0] post_left_reg;
   reg [12:0] rel_idx_reg;
   reg [7:0] elapsed_reg;
   reg [5:0] tick_cnt_reg;
   reg dma_done_reg;
   reg [15:0] dma_data_reg;

   // Trace memory in flip-flops, 4096 entries
   reg [74:0] trace_mem [0:4095];

   wire wr_ev = reg_wr_stb;
   wire ctrl_wr = wr_ev & (reg_addr == `BTC_A_CTRL);
   wire start_cmd = ctrl_wr & reg_wdata[`BTC_CTRL_START];
   wire abort_cmd = ctrl_wr & reg_wdata[`BTC_CTRL_ABORT];

   // Trigger and qualification are separate decisions
   wire capturing = (state_reg == ST_ARMED) |
      (state_reg == ST_POST);
   wire qual = cyc_ev & ~io_excl & sw_hit[`BTC_QUAL_WORD];
   wire trig = (cyc_ev & ~io_excl & (sw_hit[0] | sw_hit[1])) |
      (stop_ev & stop_trig_reg);

   // DMA entries keep address, data, direction and time only
   wire [3:0] e_ptn = s_dma ? 4'h0 : s_ptn;
   wire [15:0] e_log = s_dma ? 16'h0 : s_log;
   wire [6:0] e_flg = s_dma ? {1'b0, s_wr, 5'h00} : cyc_flags;
   // Entry: bank, displacement, table, logical, data, flags, time
   wire [74:0] entry = {s_bank, s_phys, e_ptn, e_log, s_data, e_flg,
      elapsed_reg};

   // Elapsed time tick divider
   // Divider runs free while capturing, so elapsed time is approximate
   always @(posedge core_clk) begin
      if (sys_rst | ~capturing) begin
         tick_cnt_reg <= 6'h00;
      end else if (tick_cnt_reg == (`BTC_TICK_CYC - 1)) begin
         tick_cnt_reg <= 6'h00;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 6'h01;
      end
   end
   wire tick = (tick_cnt_reg == (`BTC_TICK_CYC - 1));

   // Elapsed counter saturates, so long gaps read as maximum
   always @(posedge core_clk) begin
      if (sys_rst | start_cmd) begin
         elapsed_reg <= 8'h00;
      end else if (capturing & qual) begin
         elapsed_reg <= 8'h00;
      end else if (capturing & tick & (elapsed_reg != 8'hff)) begin
         elapsed_reg <= elapsed_reg + 8'h01;
      end
   end

   // Single write port: clearing walk or captured entry
   // An abort in the same cycle wins, so nothing lands after the stop
   wire store = capturing & qual & ~abort_cmd;
   always @(posedge core_clk) begin
      if (state_reg == ST_CLEAR) begin
         trace_mem[wr_ptr_reg] <= 75'h0;
      end else if (store) begin
         trace_mem[wr_ptr_reg] <= entry;
      end
   end

   // Capture state machine
   always @(posedge core_clk) begin
      if (sys_rst) begin
         state_reg <= ST_IDLE;
         wr_ptr_reg <= 12'h000;
         trig_idx_reg <= 12'h000;
         post_left_reg <= 12'h000;
         cpu_stop_req <= 1'b0;
      end else if (start_cmd) begin
         state_reg <= ST_CLEAR;
         wr_ptr_reg <= 12'h000;
         trig_idx_reg <= 12'h000;
         cpu_stop_req <= 1'b0;
      end else begin
         case (state_reg)
            ST_CLEAR: begin
               wr_ptr_reg <= wr_ptr_reg + 12'h001;
               if (wr_ptr_reg == `BTC_LAST_ENTRY) begin
                  state_reg <= ST_ARMED;
               end
            end
            ST_ARMED: begin
               if (abort_cmd) begin
                  state_reg <= ST_ABORTED;
                  trig_idx_reg <= wr_ptr_reg - 12'h001;
               end else begin
                  if (store) begin
                     wr_ptr_reg <= wr_ptr_reg + 12'h001;
                  end
                  if (trig) begin
                     // Unstored trigger falls back to last entry
                     trig_idx_reg <= qual ? wr_ptr_reg :
                        wr_ptr_reg - 12'h001;
                     post_left_reg <= `BTC_LAST_ENTRY - trig_pos_reg;
                     cpu_stop_req <= stop_en_reg;
                     if (trig_pos_reg == `BTC_LAST_ENTRY) begin
                        state_reg <= ST_FILLED;
                     end else begin
                        state_reg <= ST_POST;
                     end
                  end
               end
            end
            ST_POST: begin
               // Trigger index is kept, so the trigger entry stays findable
               if (abort_cmd) begin
                  state_reg <= ST_ABORTED;
               end else if (store) begin
                  wr_ptr_reg <= wr_ptr_reg + 12'h001;
                  post_left_reg <= post_left_reg - 12'h001;
                  if (post_left_reg == 12'h001) begin
                     state_reg <= ST_FILLED;
                  end
               end
            end
            ST_IDLE, ST_FILLED, ST_ABORTED: begin
               state_reg <= state_reg;
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // Software-written setup registers
   integer i;
   always @(posedge core_clk) begin
      if (sys_rst) begin
         for (i = 0; i < 24; i = i + 1) begin
            cfg_reg[i] <= 16'h0000;
         end
         cfg_reg[`BTC_SW_LEVEL] <= `BTC_RST_LEVEL_TRIG;
         cfg_reg[8+`BTC_SW_LEVEL] <= `BTC_RST_LEVEL_TRIG;
         cfg_reg[16+`BTC_SW_LEVEL] <= `BTC_RST_LEVEL_QUAL;
         stop_en_reg <= 1'b0;
         stop_trig_reg <= 1'b0;
         trig_pos_reg <= `BTC_RST_TRIG_POS;
         rel_idx_reg <= 13'h0000;
      end else if (wr_ev) begin
         if (reg_addr <= `BTC_A_CFG_LAST) begin
            cfg_reg[reg_addr[4:0]] <= reg_wdata;
         end
         if (reg_addr == `BTC_A_CTRL) begin
            stop_en_reg <= reg_wdata[`BTC_CTRL_STOP_EN];
            stop_trig_reg <= reg_wdata[`BTC_CTRL_STOP_TRIG];
         end
         // Any position from first to last entry
         if (reg_addr == `BTC_A_TRIG_POS) begin
            trig_pos_reg <= reg_wdata[11:0];
         end
         if (reg_addr == `BTC_A_REL_IDX) begin
            rel_idx_reg <= reg_wdata[12:0];
         end
      end
   end

   // Memory dump master: one word per request
   wire dma_cmd = wr_ev & (reg_addr == `BTC_A_DMA_CTRL);
   always @(posedge core_clk) begin
      if (sys_rst) begin
         dma_req <= 1'b0;
         dma_bank <= 8'h00;
         dma_addr <= 16'h0000;
         dma_done_reg <= 1'b0;
         dma_data_reg <= 16'h0000;
      end else begin
         if (wr_ev & (reg_addr == `BTC_A_DMA_ADDR) & ~dma_req) begin
            dma_addr <= reg_wdata;
         end
         // Bank moves only when software selects it
         if (wr_ev & (reg_addr == `BTC_A_DMA_BANK) & ~dma_req) begin
            dma_bank <= reg_wdata[7:0];
         end
         // Wait for acknowledge to drop so requests never overlap
         // Answer comes from the synchronised pins, two clocks after ack
         if (dma_cmd & ~dma_req & ~s_ack) begin
            dma_req <= 1'b1;
            dma_done_reg <= 1'b0;
         end else if (dma_req & s_ack) begin
            dma_req <= 1'b0;
            dma_done_reg <= 1'b1;
            dma_data_reg <= s_rdata;
            dma_addr <= dma_addr + 16'h0001;
         end
      end
   end

   // Entry addressed relative to the trigger point
   wire [11:0] rd_idx = trig_idx_reg + rel_idx_reg[11:0];
   wire [74:0] rd_entry = trace_mem[rd_idx];

   // Read mux: only trace, setup, status and dump registers leave the block
   reg [15:0] rd_mux;
   always @* begin
      rd_mux = 16'h0000;
      if (reg_addr <= `BTC_A_CFG_LAST) begin
         rd_mux = cfg_reg[reg_addr[4:0]];
      end else begin
         case (reg_addr)
            `BTC_A_CTRL: rd_mux = {12'h000, stop_trig_reg, stop_en_reg,
               2'b00};
            `BTC_A_TRIG_POS: rd_mux = {4'h0, trig_pos_reg};
            `BTC_A_STATUS: rd_mux = {12'h000, cpu_stop_req, state_reg};
            `BTC_A_REL_IDX: rd_mux = {3'b000, rel_idx_reg};
            `BTC_A_TRIG_IDX: rd_mux = {4'h0, trig_idx_reg};
            `BTC_A_E_DATA: rd_mux = rd_entry[`BTC_E_DATA];
            `BTC_A_E_PHYS: rd_mux = rd_entry[`BTC_E_PHYS];
            `BTC_A_E_BANKFLG: rd_mux = {rd_entry[`BTC_E_BANK], 1'b0,
               rd_entry[`BTC_E_FLG]};
            `BTC_A_E_PTNTIME: rd_mux = {rd_entry[`BTC_E_PTN], 4'h0,
               rd_entry[`BTC_E_TIME]};
            `BTC_A_E_LOG: rd_mux = rd_entry[`BTC_E_LOG];
            `BTC_A_WR_PTR: rd_mux = {4'h0, wr_ptr_reg};
            `BTC_A_DMA_ADDR: rd_mux = dma_addr;
            `BTC_A_DMA_BANK: rd_mux = {8'h00, dma_bank};
            `BTC_A_DMA_CTRL: rd_mux = {14'h0000, dma_done_reg, dma_req};
            `BTC_A_DMA_DATA: rd_mux = dma_data_reg;
            default: rd_mux = 16'h0000;
         endcase
      end
   end

   // Read data appears the cycle after the strobe, zero otherwise
   always @(posedge core_clk) begin
      if (sys_rst) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd_stb) begin
         reg_rdata <= rd_mux;
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

endmodule // btc_capture
`default_nettype wire

// ### include/btc_defines.vh
`ifndef BTC_DEFINES_VH
`define BTC_DEFINES_VH
// Register addresses
`define BTC_A_CFG_LAST 8'h17
`define BTC_A_CTRL 8'h20
`define BTC_A_TRIG_POS 8'h21
`define BTC_A_STATUS 8'h22
`define BTC_A_REL_IDX 8'h23
`define BTC_A_TRIG_IDX 8'h24
`define BTC_A_E_DATA 8'h25
`define BTC_A_E_PHYS 8'h26
`define BTC_A_E_BANKFLG 8'h27
`define BTC_A_E_PTNTIME 8'h28
`define BTC_A_E_LOG 8'h29
`define BTC_A_WR_PTR 8'h2a
`define BTC_A_DMA_ADDR 8'h30
`define BTC_A_DMA_BANK 8'h31
`define BTC_A_DMA_CTRL 8'h32
`define BTC_A_DMA_DATA 8'h33
// Control register bits
`define BTC_CTRL_START 0
`define BTC_CTRL_ABORT 1
`define BTC_CTRL_STOP_EN 2
`define BTC_CTRL_STOP_TRIG 3
// Select word layout: 8 slots per word, word 2 is qualification
`define BTC_SW_CARE 3
`define BTC_SW_LEVEL 6
`define BTC_QUAL_WORD 2
// Control flag positions inside the 7-bit flag field
`define BTC_FLG_IOX 6
`define BTC_FLG_WR 5
`define BTC_FLG_CPU 4
`define BTC_FLG_INST 3
`define BTC_FLG_APT 2
`define BTC_FLG_ION 1
`define BTC_FLG_PON 0
// Entry layout
`define BTC_E_TIME 7:0
`define BTC_E_FLG 14:8
`define BTC_E_DATA 30:15
`define BTC_E_LOG 46:31
`define BTC_E_PTN 50:47
`define BTC_E_PHYS 66:51
`define BTC_E_BANK 74:67
// Reset values
`define BTC_RST_TRIG_POS 12'h800
`define BTC_RST_LEVEL_TRIG 16'h0000
`define BTC_RST_LEVEL_QUAL 16'hffff
// Excluded IO device numbers
`define BTC_DEV_CONSOLE 10'h001
`define BTC_DEV_RTC 10'h00b
// Capture states
`define BTC_ST_IDLE 3'h0
`define BTC_ST_CLEAR 3'h1
`define BTC_ST_ARMED 3'h2
`define BTC_ST_POST 3'h3
`define BTC_ST_FILLED 3'h4
`define BTC_ST_ABORTED 3'h5
// Elapsed-time tick
`define BTC_CLK_NS 20
`define BTC_TICK_NS 1000
`define BTC_TICK_CYC (`BTC_TICK_NS / `BTC_CLK_NS)
`define BTC_LAST_ENTRY 12'hfff
`endif

// ### verification/btc_capture_assertions.sv
`timescale 1ns/100ps
`default_nettype none
`include "btc_defines.vh"

module btc_capture_checker (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr_stb,
   input wire logic reg_rd_stb,
   input wire logic [15:0] reg_rdata,
   // Stop and dump master
   input wire logic cpu_stop_req,
   input wire logic dma_req,
   input wire logic [7:0] dma_bank,
   input wire logic [15:0] dma_addr,
   input wire logic dma_ack
);
   logic stop_en_reg;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   // Shadow of the stop-on-trigger enable bit
   always @(posedge core_clk) begin
      if (sys_rst)
         stop_en_reg <= 1'b0;
      else if (reg_wr_stb && reg_addr == 8'h20)
         stop_en_reg <= reg_wdata[`BTC_CTRL_STOP_EN];
   end

   chk_reset_quiet: assert property ($fell(sys_rst) |-> !dma_req &&
      !cpu_stop_req && dma_addr == 16'h0000 && dma_bank == 8'h00)
      else $error("outputs not cleared by reset");
   // Read data only stands in the cycle after a read strobe
   chk_rdata_idle: assert property (!$past(reg_rd_stb) |->
      reg_rdata == 16'h0000) else $error("read data outside slot");
   // Holes in the map read as zero
   chk_hole_zero: assert property (reg_rd_stb && ((reg_addr > 8'h17 &&
      reg_addr < 8'h20) || (reg_addr > 8'h2a && reg_addr < 8'h30) ||
      reg_addr > 8'h33) |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   chk_stop_gate: assert property ($rose(cpu_stop_req) |->
      stop_en_reg) else $error("stop request while disabled");
   chk_dma_start: assert property (reg_wr_stb &&
      reg_addr == 8'h32 && !dma_req && !dma_ack && !$past(dma_ack, 2)
      |=> dma_req) else $error("dump start not taken");
   chk_dma_hold: assert property (dma_req && !dma_ack |=>
      dma_req) else $error("request dropped before answer");
   chk_dma_drop: assert property ($rose(dma_ack) && dma_req |->
      ##[1:4] !dma_req) else $error("request kept after answer");
   chk_dma_steady: assert property (dma_req && $past(dma_req) |->
      $stable(dma_addr) && $stable(dma_bank))
      else $error("dump address moved mid transfer");
   chk_dma_next: assert property ($fell(dma_req) |->
      dma_addr == $past(dma_addr) + 16'h0001 && $stable(dma_bank))
      else $error("dump address not stepped in bank");
endmodule // btc_capture_checker

bind btc_capture btc_capture_checker btc_capture_checker_inst (
   .core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr_stb, .reg_rd_stb,
   .reg_rdata, .cpu_stop_req, .dma_req, .dma_bank, .dma_addr, .dma_ack
);
`default_nettype wire

// ### verification/btc_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module btc_host_model (
   // Clock
   input wire logic core_clk,
   // Dump master of the tracer
   input wire logic dma_req,
   input wire logic [7:0] dma_bank,
   input wire logic [15:0] dma_addr,
   input wire logic [3:0] wait_cyc,
   output logic dma_ack = 1'b0,
   output logic [15:0] dma_rdata = 16'h0000
);
   int cnt = 0;

   // Memory answers after wait_cyc cycles; data follows address and bank
   always @(posedge core_clk) begin
      if (dma_req && !dma_ack) begin
         if (cnt >= wait_cyc) begin
            dma_ack <= 1'b1; // One word per grant
            dma_rdata <= dma_addr ^ {dma_bank, dma_bank};
            cnt <= 0;
         end else begin
            cnt <= cnt + 1;
         end
      end else if (!dma_req && dma_ack) begin
         dma_ack <= 1'b0;
         dma_rdata <= ~dma_rdata; // Released bus must not look valid
      end
   end
endmodule // btc_host_model
`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "btc_defines.vh"

`define CHK(a, e) begin \
   samples_checked++; \
   if ((a) !== (e)) begin \
      n_mismatch++; \
      $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); \
   end \
end

module tb_top;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr_stb = 1'b0;
   logic reg_rd_stb = 1'b0;
   logic [15:0] reg_rdata;
   logic bus_strobe = 1'b0;
   logic [7:0] bus_bank = 8'h00;
   logic [15:0] bus_phys_addr = 16'h0000;
   logic [3:0] page_table_number = 4'h0;
   logic [15:0] bus_log_addr = 16'h0000;
   logic [15:0] bus_data = 16'h0000;
   logic [6:0] flg = 7'h00; // Flag field as stored in an entry
   logic [3:0] bus_level = 4'h0;
   logic cpu_stopped = 1'b0;
   logic cpu_stop_req;
   logic dma_req;
   logic dma_ack;
   logic [7:0] dma_bank;
   logic [15:0] dma_addr;
   logic [15:0] dma_rdata;
   logic [3:0] host_wait = 4'h3;
   logic [15:0] d;
   int n_mismatch = 0;
   int samples_checked = 0;

   btc_capture btc_capture_inst (
      .core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr_stb, .reg_rd_stb,
      .reg_rdata, .bus_strobe, .bus_bank, .bus_phys_addr,
      .page_table_number, .bus_log_addr, .bus_data,
      .io_transfer_cycle(flg[6]), .bus_write(flg[5]), .bus_dma(!flg[4]),
      .bus_instr(flg[3]), .alternate_table_flag(flg[2]),
      .interrupts_on_flag(flg[1]), .paging_on_flag(flg[0]), .bus_level,
      .cpu_stopped, .cpu_stop_req, .dma_req, .dma_bank, .dma_addr,
      .dma_ack, .dma_rdata
   );

   btc_host_model btc_host_model_inst (
      .core_clk, .dma_req, .dma_bank, .dma_addr, .wait_cyc(host_wait),
      .dma_ack, .dma_rdata
   );

   // 50 MHz clock
   initial begin
      forever #10 core_clk = ~core_clk;
   end

   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr_stb <= 1'b1;
      @(posedge core_clk);
      reg_wr_stb <= 1'b0;
   endtask

   // Read data is taken in the one cycle it stands
   task automatic rd(input logic [7:0] a, output logic [15:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd_stb <= 1'b1;
      @(posedge core_clk);
      reg_rd_stb <= 1'b0;
      #1;
      v = reg_rdata;
   endtask

   task automatic chk_rd(input logic [7:0] a, input logic [15:0] e);
      rd(a, d);
      `CHK(d, e)
   endtask

   // Bounded poll of the capture state
   task automatic wst(input logic [2:0] s);
      int i;
      for (i = 0; i < 6000; i++) begin
         rd(8'h22, d);
         if (d[2:0] === s)
            break;
      end
      `CHK(d[2:0], s)
   endtask

   // One backplane cycle; fields settle a clock ahead of the strobe
   task automatic cyc(input logic [15:0] v, input logic [15:0] la,
         input logic [6:0] f);
      @(posedge core_clk);
      bus_data <= v;
      bus_log_addr <= la;
      bus_phys_addr <= la ^ 16'h4000;
      bus_bank <= 8'h03;
      page_table_number <= 4'h5;
      bus_level <= 4'h2;
      flg <= f;
      @(posedge core_clk);
      bus_strobe <= 1'b1;
      repeat (4) @(posedge core_clk);
      bus_strobe <= 1'b0;
      repeat (4) @(posedge core_clk);
   endtask

   task automatic ent(input logic [15:0] r, input logic [15:0] v,
         input logic [15:0] la, input logic [6:0] f);
      wr(8'h23, r);
      chk_rd(8'h25, v);
      chk_rd(8'h26, la ^ 16'h4000);
      chk_rd(8'h27, {8'h03, 1'b0, f});
      rd(8'h28, d);
      `CHK(d[15:12], 4'h5)
      chk_rd(8'h29, la);
   endtask

   // One dump word with the host stalling w cycles
   task automatic dump(input logic [3:0] w, input logic [15:0] a);
      int i;
      host_wait <= w;
      wr(8'h30, a);
      wr(8'h32, 16'h0001);
      repeat (2) @(posedge core_clk);
      for (i = 0; i < 100 && dma_req !== 1'b0; i++)
         @(posedge core_clk);
      #1;
      `CHK(dma_addr, a + 16'h0001)
      `CHK(dma_bank, 8'h03)
      chk_rd(8'h32, 16'h0002);
      chk_rd(8'h33, a ^ 16'h0303);
   endtask

   task automatic results;
      $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      repeat (6) @(posedge core_clk);
      sys_rst <= 1'b0;
      chk_rd(8'h21, 16'h0800);
      chk_rd(8'h22, 16'h0000);
      chk_rd(8'h1a, 16'h0000);
      // Trigger word 0 compares the data word only
      wr(8'h00, 16'h1234);
      wr(8'h03, 16'hffff);
      wr(8'h06, 16'hffff);
      wr(8'h21, 16'h0ffd);
      wr(8'h20, 16'h0001);
      wst(`BTC_ST_ARMED);
      chk_rd(8'h2a, 16'h0000);
      cyc(16'h0011, 16'h0100, 7'h36);
      cyc(16'h1234, 16'h0001, 7'h70);
      chk_rd(8'h2a, 16'h0001);
      chk_rd(8'h22, 16'h0002);
      cyc(16'h1234, 16'h0200, 7'h18);
      chk_rd(8'h22, 16'h0003);
      cyc(16'h0033, 16'h0300, 7'h36);
      chk_rd(8'h22, 16'h0003);
      repeat (500) @(posedge core_clk); // About ten elapsed-time ticks
      cyc(16'h0044, 16'h0400, 7'h2f);
      wst(`BTC_ST_FILLED);
      chk_rd(8'h24, 16'h0001);
      ent(16'h1fff, 16'h0011, 16'h0100, 7'h36);
      ent(16'h0000, 16'h1234, 16'h0200, 7'h18);
      ent(16'h0001, 16'h0033, 16'h0300, 7'h36);
      wr(8'h23, 16'h0002);
      rd(8'h28, d);
      `CHK(d[7:0] >= 8'h0a && d[7:0] <= 8'h0b, 1'b1)
      chk_rd(8'h25, 16'h0044);
      chk_rd(8'h27, 16'h0320);
      chk_rd(8'h29, 16'h0000);
      // Abort while armed
      wr(8'h20, 16'h0001);
      wst(`BTC_ST_ARMED);
      wr(8'h20, 16'h0002);
      chk_rd(8'h22, 16'h0005);
      // Qualify only data 0011, trigger last, stop the processor
      wr(8'h10, 16'h0011);
      wr(8'h13, 16'hffff);
      wr(8'h21, 16'h0fff);
      wr(8'h20, 16'h0005);
      wst(`BTC_ST_ARMED);
      cyc(16'h0011, 16'h0500, 7'h36);
      #1;
      `CHK(cpu_stop_req, 1'b0)
      cyc(16'h1234, 16'h0600, 7'h36);
      chk_rd(8'h22, 16'h000c);
      chk_rd(8'h2a, 16'h0001);
      chk_rd(8'h24, 16'h0000);
      // Processor stop as the only trigger, nothing stored yet
      wr(8'h20, 16'h0009);
      chk_rd(8'h20, 16'h0008);
      wst(`BTC_ST_ARMED);
      @(posedge core_clk);
      cpu_stopped <= 1'b1;
      repeat (4) @(posedge core_clk);
      chk_rd(8'h22, 16'h0004);
      chk_rd(8'h24, 16'h0fff);
      cpu_stopped <= 1'b0;
      // Dump words, the first wrapping inside its bank
      wr(8'h31, 16'h0003);
      dump(4'h3, 16'hffff);
      dump(4'h0, 16'h1000);
      results();
   end

   // About 17k cycles are needed; a hang is cut at 1 ms
   initial begin
      #1000000;
      n_mismatch++;
      results();
   end
endmodule // tb_top
`default_nettype wire
